// ### pkg/aof_pkg.sv
package aof_pkg;
	// ==========================================================
	// data path
	localparam int DATA_W = 16;
	localparam int DITHER_W = 16;
	localparam logic [15:0] DITHER_SEED = 16'hace1;
	localparam logic [15:0] DITHER_TAPS = 16'hb400;
	// ==========================================================
	// register map
	localparam logic [11:0] CTRL_OFF = 12'h000;
	localparam logic [11:0] STAT_OFF = 12'h004;
	localparam logic [11:0] IRQ_OFF = 12'h008;
	localparam logic [11:0] MASK_OFF = 12'h00c;
	localparam logic [11:0] LAST_OFF = 12'h010;
	localparam int CTRL_FMT_LSB = 0;
	localparam int CTRL_BUS_LSB = 2;
	localparam int CTRL_SCR_BIT = 4;
	localparam int CTRL_DTH_BIT = 5;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [1:0] IRQ_RESET = 2'h0;
	localparam int IRQ_RANGE_BIT = 0;
	localparam int IRQ_CLK_BIT = 1;

	// bus modes
	typedef enum logic [1:0] {
		AOF_CMOS_FULL = 2'h0,
		AOF_CMOS_DEMUX = 2'h1,
		AOF_LVDS_LOW = 2'h2,
		AOF_LVDS_STD = 2'h3
	} aof_bus_e;

	typedef struct packed {
		logic [15:0] data;
		logic        range_flag;
	} aof_word_s;

	typedef struct packed {
		logic       two_comp;
		logic       stabilizer;
	} aof_fmt_s;
endpackage : aof_pkg

// ### rtl/aof_formatter.sv
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
// What this block does
// - format level 0..3 gives ob/off, ob/on, tc/on, tc/off.
// - range flag follows the current result's over or under range.
// - cmos modes drive separate high flags for bus a and bus b.
// - lvds mode drives one differential range flag, positive means set.
// - in full rate, sample clock out b is a delayed copy of the encode input, clock a its inverse.
// - cmos bus a changes when clock a falls and clock b rises.
// - demux bus b changes at the same edge as bus a.
// - full rate uses bus a only, captured on clock a rise.
// - demux output clocks toggle at half encode rate, samples alternate.
// - scrambling xors every bit above lsb with the lsb.
// - scrambling leaves lsb, range flags and clocks untouched.
// - scrambling only while scramble select or the ctrl scramble bit is high.
// - dither lfsr drives the dac and is subtracted from each result.
// - every output word is sixteen bits in the selected coding.
// - bus level 0..3 gives full cmos, demux cmos, low lvds, lvds.
module aof_formatter #(
	parameter int W = aof_pkg::DATA_W
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [11:0]  paddr,
	input  wire logic [31:0]  pwdata,
	output logic      [31:0]  prdata,
	output logic              pready,
	output logic              pslverr,
	output logic              irq,
	input  wire logic         encode_input,
	input  wire logic [W-1:0] conv_data,
	input  wire logic         conv_over,
	input  wire logic         conv_under,
	input  wire logic         scramble_select,
	output logic      [W-1:0] dither_value,
	output logic              stabilizer_on,
	output logic      [W-1:0] bus_a,
	output logic      [W-1:0] bus_b,
	output logic              range_flag_bus_a,
	output logic              range_flag_bus_b,
	output logic              range_flag_p,
	output logic              range_flag_n,
	output logic              sample_clock_out_a,
	output logic              sample_clock_out_b,
	output logic              lvds_mode,
	output logic              lvds_low_power
);
	default clocking chk_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ==========================================================
	// synchronisers
	logic [1:0] encode_sync_reg;
	logic [1:0] scr_sync_reg;
	logic       encode_d_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			encode_sync_reg <= 2'h0;
			scr_sync_reg <= 2'h0;
			encode_d_reg <= 1'b0;
		end else begin
			encode_sync_reg <= {encode_sync_reg[0], encode_input};
			scr_sync_reg <= {scr_sync_reg[0], scramble_select};
			encode_d_reg <= encode_sync_reg[1];
		end
	end
	wire encode_rise = encode_sync_reg[1] & ~encode_d_reg;
	wire encode_fall = ~encode_sync_reg[1] & encode_d_reg;

	// ==========================================================
	// registers
	logic [31:0] ctrl_reg;
	logic [1:0]  irq_reg;
	logic [1:0]  mask_reg;
	wire         wr_en = psel & penable & pwrite;
	wire         rd_hit = paddr < aof_pkg::LAST_OFF && paddr[1:0] == 2'h0;
	wire         wr_ctrl = wr_en && paddr == aof_pkg::CTRL_OFF;
	wire         wr_irq = wr_en && paddr == aof_pkg::IRQ_OFF;
	wire         wr_mask = wr_en && paddr == aof_pkg::MASK_OFF;
	wire [1:0]   fmt_lvl = ctrl_reg[aof_pkg::CTRL_FMT_LSB +: 2];
	wire [1:0]   bus_lvl = ctrl_reg[aof_pkg::CTRL_BUS_LSB +: 2];
	wire         dither_en = ctrl_reg[aof_pkg::CTRL_DTH_BIT];
	// either the pin or the soft bit turns scrambling on
	wire         scr_on = scr_sync_reg[1] |
		ctrl_reg[aof_pkg::CTRL_SCR_BIT];
	aof_pkg::aof_fmt_s fmt;
	assign fmt.two_comp = fmt_lvl[1];
	assign fmt.stabilizer = fmt_lvl[1] ^ fmt_lvl[0];
	aof_pkg::aof_bus_e bus_mode;
	assign bus_mode = aof_pkg::aof_bus_e'(bus_lvl);
	wire demux = bus_mode == aof_pkg::AOF_CMOS_DEMUX;

	// ==========================================================
	// dither generator
	logic [15:0] lfsr_reg;
	wire  [15:0] lfsr_next = lfsr_reg[0] ?
		((lfsr_reg >> 1) ^ aof_pkg::DITHER_TAPS) : (lfsr_reg >> 1);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) lfsr_reg <= aof_pkg::DITHER_SEED;
		else if (encode_rise && dither_en) lfsr_reg <= lfsr_next;
	end

	// ==========================================================
	// word path
	wire [W-1:0] dith_used = dither_en ? lfsr_reg[W-1:0] : '0;
	wire [W-1:0] corrected = conv_data - dith_used;
	wire [W-1:0] coded = fmt.two_comp ?
		{~corrected[W-1], corrected[W-2:0]} : corrected;
	// lsb copied straight through, upper bits xored with it
	wire [W-1:0] scrambled = scr_on ?
		{coded[W-1:1] ^ {(W-1){coded[0]}}, coded[0]} : coded;
	aof_pkg::aof_word_s word;
	assign word.data = scrambled;
	assign word.range_flag = conv_over | conv_under;

	// ==========================================================
	// output stage, updated on synced encode rise
	logic [W-1:0] bus_a_reg;
	logic [W-1:0] bus_b_reg;
	logic         flag_a_reg;
	logic         flag_b_reg;
	logic         phase_reg;
	logic         clk_a_reg;
	logic         dly_clk_reg;
	logic [W-1:0] pend_data_reg;
	logic         pend_flag_reg;
	wire          take_b = demux & phase_reg;
	wire          load_a = encode_rise & ~demux;
	wire          load_pair = encode_rise & take_b;
	wire          hold_first = encode_rise & demux & ~phase_reg;
	// demux holds the a sample so both buses change on one clock a fall
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_a_reg <= '0;
			bus_b_reg <= '0;
			flag_a_reg <= 1'b0;
			flag_b_reg <= 1'b0;
			phase_reg <= 1'b0;
			pend_data_reg <= '0;
			pend_flag_reg <= 1'b0;
		end else begin
			if (encode_rise) phase_reg <= demux ? ~phase_reg : 1'b0;
			if (hold_first) begin
				pend_data_reg <= word.data;
				pend_flag_reg <= word.range_flag;
			end
			if (load_a) begin
				bus_a_reg <= word.data;
				flag_a_reg <= word.range_flag;
			end else if (load_pair) begin
				bus_a_reg <= pend_data_reg;
				flag_a_reg <= pend_flag_reg;
				bus_b_reg <= word.data;
				flag_b_reg <= word.range_flag;
			end
		end
	end
	// clock a falls whenever a bus changes, rises half a period later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_a_reg <= 1'b0;
			dly_clk_reg <= 1'b0;
		end else begin
			dly_clk_reg <= encode_sync_reg[1];
			if (load_a || load_pair) clk_a_reg <= 1'b0;
			else if (hold_first) clk_a_reg <= 1'b1;
			else if (encode_fall && !demux) clk_a_reg <= 1'b1;
		end
	end
	assign bus_a = bus_a_reg;
	assign bus_b = bus_b_reg;
	assign range_flag_bus_a = flag_a_reg;
	assign range_flag_bus_b = flag_b_reg;
	assign range_flag_p = flag_a_reg;
	assign range_flag_n = ~flag_a_reg;
	assign sample_clock_out_a = clk_a_reg;
	assign sample_clock_out_b = ~clk_a_reg;
	assign dither_value = dith_used;
	assign stabilizer_on = fmt.stabilizer;
	assign lvds_mode = bus_lvl[1];
	assign lvds_low_power = bus_mode == aof_pkg::AOF_LVDS_LOW;

	// ==========================================================
	// interrupts: set wins over write-one clear
	wire [1:0] ev = {load_pair, encode_rise & word.range_flag};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= aof_pkg::CTRL_RESET;
			irq_reg <= aof_pkg::IRQ_RESET;
			mask_reg <= aof_pkg::IRQ_RESET;
		end else begin
			if (wr_ctrl) ctrl_reg <= pwdata;
			if (wr_mask) mask_reg <= pwdata[1:0];
			irq_reg <= (irq_reg & ~(wr_irq ? pwdata[1:0] : 2'h0)) | ev;
		end
	end
	assign irq = |(irq_reg & mask_reg);

	// ==========================================================
	// apb read
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (paddr)
			aof_pkg::CTRL_OFF: rd_mux = {26'h0, ctrl_reg[5:0]};
			aof_pkg::STAT_OFF: rd_mux = {24'h0, flag_b_reg, flag_a_reg,
				phase_reg, clk_a_reg, scr_on, demux, fmt.stabilizer,
				fmt.two_comp};
			aof_pkg::IRQ_OFF:  rd_mux = {30'h0, irq_reg};
			aof_pkg::MASK_OFF: rd_mux = {30'h0, mask_reg};
			default:           rd_mux = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite) prdata <= rd_mux;
	end
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~rd_hit;

	// ==========================================================
	// checks: default clock pclk, all disabled in reset
	// ----- coding
	fmt_ob_off_a: assert property (
		fmt_lvl == 2'h0 |-> !fmt.two_comp && !fmt.stabilizer)
		else $error("format level zero wrong");

	fmt_ob_on_a: assert property (
		fmt_lvl == 2'h1 |-> !fmt.two_comp && fmt.stabilizer)
		else $error("format level one wrong");

	fmt_tc_a: assert property (
		fmt_lvl == 2'h2 |-> fmt.two_comp && fmt.stabilizer)
		else $error("format level two wrong");

	fmt_tc_off_a: assert property (
		fmt_lvl == 2'h3 |-> fmt.two_comp && !fmt.stabilizer)
		else $error("format level three wrong");

	tc_msb_a: assert property (
		fmt.two_comp |-> coded[W-1] != corrected[W-1])
		else $error("twos complement msb not flipped");

	tc_low_a: assert property (
		coded[W-2:0] == corrected[W-2:0])
		else $error("coding touched low bits");

	ob_pass_a: assert property (
		!fmt.two_comp |-> coded == corrected)
		else $error("offset binary altered");

	// ----- scrambling
	// the lsb is the key for the receiver, so it must pass untouched
	scr_lsb_a: assert property (
		scrambled[0] == coded[0])
		else $error("scramble changed lsb");

	scr_xor_a: assert property (
		scr_on |-> scrambled[W-1] == (coded[W-1] ^ coded[0]))
		else $error("scramble xor wrong");

	scr_mid_a: assert property (
		scr_on |-> scrambled[1] == (coded[1] ^ coded[0]))
		else $error("scramble xor wrong on bit one");

	scr_off_a: assert property (
		!scr_on |-> scrambled == coded)
		else $error("data scrambled while off");

	// ----- dither
	dither_off_a: assert property (
		!dither_en |-> dither_value == '0)
		else $error("dither leaked while off");

	dither_sub_a: assert property (
		conv_data == corrected + dither_value)
		else $error("dither not subtracted");

	dither_step_a: assert property (
		encode_rise && dither_en |=> lfsr_reg != $past(lfsr_reg))
		else $error("dither sequence stalled");

	dither_hold_a: assert property (
		!(encode_rise && dither_en) |=> $stable(lfsr_reg))
		else $error("dither moved between samples");

	// ----- range flags
	range_or_a: assert property (
		word.range_flag == (conv_over || conv_under))
		else $error("range flag does not follow result");

	flag_a_a: assert property (
		load_a |=> flag_a_reg == $past(word.range_flag))
		else $error("bus a flag not loaded");

	flag_b_a: assert property (
		load_pair |=> flag_b_reg == $past(word.range_flag))
		else $error("bus b flag not loaded");

	flag_pair_a: assert property (
		load_pair |=> flag_a_reg == $past(pend_flag_reg))
		else $error("bus a flag lost its sample");

	lvds_flag_a: assert property (
		range_flag_p != range_flag_n)
		else $error("range pair not differential");

	// ----- output clocks and buses
	dly_clk_a: assert property (
		dly_clk_reg == $past(encode_sync_reg[1]))
		else $error("delayed clock lost the encode");

	clk_b_a: assert property (
		sample_clock_out_b != sample_clock_out_a)
		else $error("clock b not inverse of a");

	full_clk_a: assert property (
		load_a |=> !clk_a_reg)
		else $error("clock a not low at bus a change");

	full_rise_a: assert property (
		encode_fall && !demux |=> clk_a_reg)
		else $error("clock a did not follow encode");

	full_a_load_a: assert property (
		load_a |=> bus_a_reg == $past(word.data))
		else $error("bus a not loaded in full rate");

	full_b_a: assert property (
		encode_rise && bus_mode == aof_pkg::AOF_CMOS_FULL |=>
		$stable(bus_b_reg))
		else $error("bus b moved in full rate");

	demux_ph_a: assert property (
		encode_rise && demux && demux == $past(demux) |=>
		phase_reg != $past(phase_reg))
		else $error("demux phase did not toggle");

	demux_rise_a: assert property (
		hold_first |=> clk_a_reg)
		else $error("clock a did not rise mid pair");

	demux_fall_a: assert property (
		load_pair |=> !clk_a_reg)
		else $error("clock a did not fall at pair");

	demux_pair_a: assert property (
		load_pair |=> bus_b_reg == $past(word.data) &&
		bus_a_reg == $past(pend_data_reg))
		else $error("demux pair not shown together");

	demux_hold_a: assert property (
		demux && !load_pair |=> $stable(bus_a_reg) && $stable(bus_b_reg))
		else $error("bus moved away from clock a fall");

	// ----- interrupt flags: a new event beats a same-cycle clear
	irq_set_a: assert property (
		encode_rise && word.range_flag |=>
		irq_reg[aof_pkg::IRQ_RANGE_BIT])
		else $error("range event lost");

	irq_pair_a: assert property (
		load_pair |=> irq_reg[aof_pkg::IRQ_CLK_BIT])
		else $error("pair event lost");
endmodule : aof_formatter

// ### dv/aof_rx_model.sv
`timescale 1ns/1ps
// ==========================================================
// receiving logic: latches both buses on clock a rise
module aof_rx_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        descr,
	input  wire logic [15:0] bus_a,
	input  wire logic [15:0] bus_b,
	input  wire logic        flag_a,
	input  wire logic        clk_a,
	output logic      [15:0] raw_a,
	output logic      [15:0] word_a,
	output logic      [15:0] word_b,
	output logic             flag_cap
);
	logic clk_a_q;
	function automatic logic [15:0] unscr(input logic [15:0] v);
		return v ^ {{15{v[0]}}, 1'b0};
	endfunction : unscr
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_a_q  <= 1'b0;
			raw_a    <= 16'h0000;
			word_a   <= 16'h0000;
			word_b   <= 16'h0000;
			flag_cap <= 1'b0;
		end else begin
			clk_a_q <= clk_a;
			if (clk_a && !clk_a_q) begin
				raw_a    <= bus_a;
				word_a   <= descr ? unscr(bus_a) : bus_a;
				word_b   <= descr ? unscr(bus_b) : bus_b;
				flag_cap <= flag_a;
			end
		end
	end
endmodule : aof_rx_model

// ### dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, irq, e, stabilizer_on, lvds_mode, lvds_low_power;
	logic encode_input = 0, conv_over = 0, conv_under = 0;
	logic scramble_select = 0, range_flag_bus_a, range_flag_bus_b;
	logic [15:0] conv_data = 16'h0, dither_value, bus_a, bus_b;
	logic [15:0] raw, wa, wb;
	logic range_flag_p, range_flag_n, sample_clock_out_a, sample_clock_out_b;
	logic fcap;
	int error_cnt = 0, n_checks = 0;
	always #2.5 pclk = ~pclk;
	aof_formatter uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .irq, .encode_input, .conv_data,
		.conv_over, .conv_under, .scramble_select, .dither_value,
		.stabilizer_on, .bus_a, .bus_b, .range_flag_bus_a, .range_flag_bus_b,
		.range_flag_p, .range_flag_n, .sample_clock_out_a, .sample_clock_out_b,
		.lvds_mode, .lvds_low_power);
	aof_rx_model rx (.pclk, .presetn, .descr(scramble_select), .bus_a, .bus_b,
		.flag_a(range_flag_bus_a), .clk_a(sample_clock_out_a), .raw_a(raw),
		.word_a(wa), .word_b(wb), .flag_cap(fcap));
	task automatic print_verdict();
		if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata; e = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	function automatic logic [15:0] lstep(input logic [15:0] v);
		return v[0] ? ((v >> 1) ^ aof_pkg::DITHER_TAPS) : (v >> 1);
	endfunction : lstep
	// one encode period of 125 ns, data held across the whole period
	task automatic smp(input logic [15:0] d, input logic [1:0] ou);
		conv_data <= d; {conv_over, conv_under} <= ou;
		encode_input <= 1'b1;
		repeat (13) @(posedge pclk);
		encode_input <= 1'b0;
		repeat (12) @(posedge pclk);
	endtask : smp
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(range_flag_n, 1); chk(sample_clock_out_b, 1);
		apb(0, aof_pkg::CTRL_OFF, 0); chk(q, aof_pkg::CTRL_RESET);
		apb(0, 12'h040, 0); chk(e, 1);
		for (int f = 0; f < 4; f++) begin
			apb(1, aof_pkg::CTRL_OFF, f);
			smp(16'h1235, 0); smp(16'h1235, 0);
			chk(stabilizer_on, (f == 1 || f == 2));
			chk(wa, (f >= 2) ? 16'h9235 : 16'h1235);
			chk(dither_value, 0);
			chk(sample_clock_out_b, !sample_clock_out_a);
		end
		for (int b = 0; b < 4; b++) begin
			apb(1, aof_pkg::CTRL_OFF, b << 2);
			chk(lvds_mode, b >= 2); chk(lvds_low_power, b == 2);
		end
		apb(1, aof_pkg::CTRL_OFF, 0);
		scramble_select <= 1'b1;
		smp(16'h00f1, 0); smp(16'h00f1, 0);
		chk(raw, 16'hff0f); chk(wa, 16'h00f1);
		scramble_select <= 1'b0;
		smp(16'h00f1, 0); smp(16'h00f1, 0);
		chk(raw, 16'h00f1);
		apb(1, aof_pkg::MASK_OFF, 1);
		smp(16'hffff, 2'b10); smp(16'hffff, 2'b10);
		chk(fcap, 1); chk(irq, 1);
		smp(16'h4000, 0); smp(16'h4000, 0);
		chk(fcap, 0);
		apb(0, aof_pkg::IRQ_OFF, 0); chk(q[0], 1);
		apb(1, aof_pkg::IRQ_OFF, 3); chk(irq, 0);
		apb(1, aof_pkg::CTRL_OFF, 32'hc);
		smp(16'h0000, 2'b01); smp(16'h0000, 2'b01);
		chk(range_flag_p, 1); chk(range_flag_n, 0);
		smp(16'h0000, 0); smp(16'h0000, 0);
		chk(range_flag_p, 0);
		apb(1, aof_pkg::CTRL_OFF, 32'h4);
		for (int i = 0; i < 3; i++) begin
			smp(16'h2222, 0); smp(16'h5555, 0);
		end
		chk(wa, 16'h2222); chk(wb, 16'h5555);
		apb(0, aof_pkg::IRQ_OFF, 0); chk(q[1], 1);
		apb(1, aof_pkg::CTRL_OFF, 32'h20);
		smp(16'h3000, 0); smp(16'h3000, 0);
		chk(dither_value != 16'h0000, 1);
		chk(wa, 16'(16'h3000 - lstep(aof_pkg::DITHER_SEED)));
		chk(dither_value, lstep(lstep(aof_pkg::DITHER_SEED)));
		print_verdict();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		print_verdict();
	end
endmodule : tb_top
